// File: logic/pc_core.sv
/*
  Program counter, return stack, indirect access port, timer clock
  counter, external interrupt edges and wake-on-change of the core.
  Assumes mclk_in is the instruction clock and that the decoder issues
  at most one sequencing command and one register access per cycle.
*/
// What this block does
// - Indirect port accesses memory at pointer
// - Timer counts pin edges or instruction cycles
// - Timer readable and writable like registers
// - Twelve-bit counter addresses 4K words
// - Reset clears program counter to zero
// - Jump loads low ten counter bits
// - Call loads low ten, pushes next address
// - Returns reload counter from stack top
// - Add accumulator carries into upper bits
// - Move replaces low eight, keeps bits 8-9
// - Jump and call take page bits high
// - First interrupt edge chosen by config bit
// - Second interrupt fires on falling edge
// - Interrupt pin change wakes sleep and idle
// - Port 6 and general I/O port 8 pin change wakes sleep and idle
// - Low reset pin holds device in reset
// - Counter pin works normal, green, idle
// - Page bits select four 1K pages
// - Returns keep page bits, restore full address
// - Pointer low six bits pick register
`timescale 1ns/10ps
`include "pc_core_regs.svh"

module pc_core
  import pc_core_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic reset_n_pin_in,
  // decoder side
  input wire seq_cmd_t cmd_in,
  input wire reg_req_t req_in,
  input wire power_mode_t mode_in,
  input wire logic tcc_src_ext_in,
  input wire logic [7:0] port_config_reg_in,
  // pins
  input wire logic tcc_pin_in,
  input wire logic ext_irq_a_in,
  input wire logic ext_irq_b_in,
  input wire logic [7:0] port6_pin_in,
  input wire logic [7:0] port8_pin_in,
  input wire logic [7:0] port8_gpio_en_in,
  // results
  output logic [`PC_WIDTH-1:0] fetch_addr_out,
  output logic [7:0] rdata_out,
  output logic rdata_valid_out,
  output logic [1:0] page_select_bits_out,
  output logic [7:0] timer_clock_counter_out,
  output logic irq_a_out,
  output logic irq_b_out,
  output logic wake_out,
  output logic stack_overflow_out,
  output logic in_reset_out
);

  logic rstn_s1_q;
  logic rstn_s2_q;
  logic rst_int;
  logic [2:0] tcc_sync_q;
  logic [2:0] irq_a_sync_q;
  logic [2:0] irq_b_sync_q;
  logic [7:0] p6_s1_q;
  logic [7:0] p6_s2_q;
  logic [7:0] p6_prev_q;
  logic [7:0] p8_s1_q;
  logic [7:0] p8_s2_q;
  logic [7:0] p8_prev_q;
  logic [`PC_WIDTH-1:0] pc_q;
  logic [`PC_WIDTH-1:0] pc_d;
  logic [`PC_WIDTH-1:0] stack_q [`STACK_DEPTH];
  logic [`STACK_PTR_WIDTH:0] sp_q;
  logic [`STACK_PTR_WIDTH:0] sp_d;
  logic [7:0] tcc_q;
  logic [7:0] status_q;
  logic [7:0] rsr_q;
  logic [7:0] data_mem_q [`DATA_WORDS];
  logic [5:0] eff_addr;
  logic [1:0] page_bits;
  logic [`PC_WIDTH-1:0] stack_top;
  logic is_ret;
  logic tcc_ext_edge;
  logic tcc_tick;
  logic ext_ok;
  logic irq_a_rise;
  logic irq_a_fall;
  logic irq_b_fall;
  logic [7:0] p6_change;
  logic [7:0] p8_change;
  logic pin_change;
  logic [7:0] rdata_q;
  logic rdata_valid_q;
  logic irq_a_q;
  logic irq_b_q;
  logic wake_q;
  logic ovf_q;

  // external reset pin, two-stage sync; held low keeps rst_int high, resetting all but the pin syncs and memories
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rstn_s1_q <= 1'b0;
      rstn_s2_q <= 1'b0;
    end else begin
      rstn_s1_q <= reset_n_pin_in;
      rstn_s2_q <= rstn_s1_q;
    end
  end
  assign rst_int = sys_rst_in | ~rstn_s2_q;

  // pin synchronisers: bits 0,1 sync, bit 2 previous value for edges;
  // no reset, so the chains follow the pins and reset leaves no false edge
  always_ff @(posedge mclk_in) begin
    tcc_sync_q <= {tcc_sync_q[1:0], tcc_pin_in};
    irq_a_sync_q <= {irq_a_sync_q[1:0], ext_irq_a_in};
    irq_b_sync_q <= {irq_b_sync_q[1:0], ext_irq_b_in};
  end

  // port pins: one sync pair plus previous sample per bit
  genvar g;
  for (g = 0; g < 8; g++) begin : g_port_sync
    always_ff @(posedge mclk_in) begin
      p6_s1_q[g] <= port6_pin_in[g];
      p6_s2_q[g] <= p6_s1_q[g];
      p6_prev_q[g] <= p6_s2_q[g];
      p8_s1_q[g] <= port8_pin_in[g];
      p8_s2_q[g] <= p8_s1_q[g];
      p8_prev_q[g] <= p8_s2_q[g];
    end
    assign p6_change[g] = p6_s2_q[g] ^ p6_prev_q[g];
    // segment pins only count while used as general I/O
    assign p8_change[g] = port8_gpio_en_in[g] & (p8_s2_q[g] ^ p8_prev_q[g]);
  end

  // edge detection uses stages 2 and 3, never stage 1
  assign irq_a_rise = irq_a_sync_q[1] & ~irq_a_sync_q[2];
  assign irq_a_fall = ~irq_a_sync_q[1] & irq_a_sync_q[2];
  assign irq_b_fall = ~irq_b_sync_q[1] & irq_b_sync_q[2];
  assign tcc_ext_edge = tcc_sync_q[1] & ~tcc_sync_q[2];
  assign pin_change = (|p6_change) | (|p8_change) | (irq_a_sync_q[1] ^ irq_a_sync_q[2])
    | (irq_b_sync_q[1] ^ irq_b_sync_q[2]);

  // counter pin is dead in sleep; cycle counting runs in normal and green only
  assign ext_ok = (mode_in != MODE_SLEEP);
  assign tcc_tick = tcc_src_ext_in ? (tcc_ext_edge & ext_ok)
    : (mode_in == MODE_NORMAL || mode_in == MODE_GREEN);

  always_ff @(posedge mclk_in) begin
    if (rst_int) begin
      irq_a_q <= 1'b0;
      irq_b_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_a_q <= port_config_reg_in[`PORT_CONFIG_EDGE_BIT] ? irq_a_rise : irq_a_fall;
      irq_b_q <= irq_b_fall;
      wake_q <= pin_change & (mode_in == MODE_SLEEP || mode_in == MODE_IDLE);
    end
  end

  // operand address: port 0 redirects through the pointer
  assign eff_addr = (req_in.addr == `OFS_INDIRECT_ACCESS_PORT)
    ? rsr_q[`RSR_INDEX_HI:0] : req_in.addr;
  assign page_bits = status_q[`STATUS_PAGE_HI:`STATUS_PAGE_LO];
  assign is_ret = (cmd_in.op == OP_RET) || (cmd_in.op == OP_RET_LIT)
    || (cmd_in.op == OP_RET_INT);
  assign stack_top = stack_q[sp_q[`STACK_PTR_WIDTH-1:0] - 3'h1];

  // next program counter; sequencing command has priority over bus write
  always_comb begin
    pc_d = pc_q;
    sp_d = sp_q;
    case (cmd_in.op)
      OP_STEP: pc_d = pc_q + 12'h001;
      OP_JUMP: pc_d = {page_bits, cmd_in.imm};
      OP_CALL: begin
        pc_d = {page_bits, cmd_in.imm};
        sp_d = sp_q + 4'h1;
      end
      OP_RET, OP_RET_LIT, OP_RET_INT: begin
        pc_d = stack_top;
        sp_d = sp_q - 4'h1;
      end
      OP_ADD_PC: pc_d = pc_q + {4'h0, cmd_in.acc};
      OP_MOV_PC: pc_d = {page_bits, pc_q[9:8], cmd_in.acc};
      OP_NONE: begin
        if (req_in.wr && eff_addr == `OFS_PROGRAM_COUNTER) begin
          pc_d = {page_bits, pc_q[9:8], req_in.wdata};
        end
      end
      default: pc_d = pc_q;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_int) begin
      pc_q <= `PC_RESET;
    end else begin
      pc_q <= pc_d;
    end
  end

  // return stack; pointer counts entries, index wraps so a ninth call
  // overwrites the oldest entry and raises the sticky overflow
  always_ff @(posedge mclk_in) begin
    if (rst_int) begin
      sp_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      sp_q <= sp_d;
      if (cmd_in.op == OP_CALL && sp_q == 4'h8) begin
        ovf_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (cmd_in.op == OP_CALL && !rst_int) begin
      stack_q[sp_q[`STACK_PTR_WIDTH-1:0]] <= pc_q + 12'h001;
    end
  end

  // timer: a program write wins over the count in that cycle
  always_ff @(posedge mclk_in) begin
    if (rst_int) begin
      tcc_q <= `TCC_RESET;
    end else if (req_in.wr && eff_addr == `OFS_TIMER_CLOCK_COUNTER) begin
      tcc_q <= req_in.wdata;
    end else if (tcc_tick) begin
      tcc_q <= tcc_q + 8'h01;
    end
  end

  // status and pointer registers; returns never touch page bits
  always_ff @(posedge mclk_in) begin
    if (rst_int) begin
      status_q <= `STATUS_RESET;
      rsr_q <= `RSR_RESET;
    end else if (req_in.wr) begin
      if (eff_addr == `OFS_STATUS) begin
        status_q <= req_in.wdata;
      end
      if (eff_addr == `OFS_RAM_SELECT_POINTER) begin
        rsr_q <= req_in.wdata;
      end
    end
  end

  // general registers; indirect write lands at pointer location
  always_ff @(posedge mclk_in) begin
    if (!rst_int && req_in.wr && eff_addr > `OFS_RAM_SELECT_POINTER) begin
      data_mem_q[eff_addr] <= req_in.wdata;
    end
  end

  // read port, one cycle latency; pointer to itself reads zero
  always_ff @(posedge mclk_in) begin
    if (rst_int) begin
      rdata_q <= 8'h00;
      rdata_valid_q <= 1'b0;
    end else begin
      rdata_valid_q <= req_in.rd;
      if (req_in.rd) begin
        case (eff_addr)
          `OFS_INDIRECT_ACCESS_PORT: rdata_q <= 8'h00;
          `OFS_TIMER_CLOCK_COUNTER: rdata_q <= tcc_q;
          `OFS_PROGRAM_COUNTER: rdata_q <= pc_q[7:0];
          `OFS_STATUS: rdata_q <= status_q;
          `OFS_RAM_SELECT_POINTER: rdata_q <= rsr_q;
          default: rdata_q <= data_mem_q[eff_addr];
        endcase
      end
    end
  end

  assign fetch_addr_out = pc_q;
  assign rdata_out = rdata_q;
  assign rdata_valid_out = rdata_valid_q;
  assign page_select_bits_out = page_bits;
  assign timer_clock_counter_out = tcc_q;
  assign irq_a_out = irq_a_q;
  assign irq_b_out = irq_b_q;
  assign wake_out = wake_q;
  assign stack_overflow_out = ovf_q;
  assign in_reset_out = rst_int;

  // checks
  sequence s_call_then_ret;
    (cmd_in.op == OP_CALL) ##1 is_ret;
  endsequence

  sequence s_pin_low_two;
    !reset_n_pin_in ##1 !reset_n_pin_in;
  endsequence

  AST_RESET_CLEARS_PC: assert property (
    @(posedge mclk_in) rst_int |=> (pc_q == 12'h000))
    else $error("program counter not zero after reset");

  AST_PIN_HOLDS_RESET: assert property (
    @(posedge mclk_in) s_pin_low_two |=> in_reset_out)
    else $error("low reset pin did not hold reset");

  AST_JUMP_LOAD: assert property (
    @(posedge mclk_in) disable iff (rst_int)
    (cmd_in.op == OP_JUMP) |=> (pc_q[9:0] == $past(cmd_in.imm)))
    else $error("jump target not loaded");

  AST_PAGE_HIGH_BITS: assert property (
    @(posedge mclk_in) disable iff (rst_int)
    (cmd_in.op == OP_JUMP || cmd_in.op == OP_CALL)
      |=> (pc_q[11:10] == $past(page_bits)))
    else $error("page bits not loaded into counter");

  AST_CALL_RET_RESTORE: assert property (
    @(posedge mclk_in) disable iff (rst_int)
    s_call_then_ret |=> (pc_q == $past(pc_q, 2) + 12'h001))
    else $error("return did not restore call address");

  AST_RET_POPS: assert property (
    @(posedge mclk_in) disable iff (rst_int)
    is_ret |=> (sp_q[2:0] == $past(sp_q[2:0]) - 3'h1))
    else $error("return did not pop the stack");

  AST_MOV_KEEPS_89: assert property (
    @(posedge mclk_in) disable iff (rst_int)
    (cmd_in.op == OP_MOV_PC)
      |=> (pc_q[9:8] == $past(pc_q[9:8])) && (pc_q[7:0] == $past(cmd_in.acc)))
    else $error("move into counter changed bits 8-9");

  AST_ADD_CARRIES: assert property (
    @(posedge mclk_in) disable iff (rst_int)
    (cmd_in.op == OP_ADD_PC) |=> (pc_q == $past(pc_q) + {4'h0, $past(cmd_in.acc)}))
    else $error("relative add did not carry upward");

  AST_STEP_ONE: assert property (
    @(posedge mclk_in) disable iff (rst_int)
    (cmd_in.op == OP_STEP) |=> (pc_q == $past(pc_q) + 12'h001))
    else $error("sequential step not by one");

  AST_TCC_WRITE: assert property (
    @(posedge mclk_in) disable iff (rst_int)
    (req_in.wr && eff_addr == `OFS_TIMER_CLOCK_COUNTER)
      |=> (tcc_q == $past(req_in.wdata)))
    else $error("timer write lost");

  AST_TCC_TICK: assert property (
    @(posedge mclk_in) disable iff (rst_int)
    (tcc_tick && !req_in.wr) |=> (tcc_q == $past(tcc_q) + 8'h01))
    else $error("timer missed a count");

  AST_IRQ_B_FALL: assert property (
    @(posedge mclk_in) disable iff (rst_int)
    irq_b_out |-> $past(irq_b_sync_q[2]) && !$past(irq_b_sync_q[1]))
    else $error("second interrupt without falling edge");

  AST_WAKE_CAUSE: assert property (
    @(posedge mclk_in) disable iff (rst_int)
    wake_out |-> ($past(mode_in) == MODE_SLEEP || $past(mode_in) == MODE_IDLE))
    else $error("wake raised outside sleep or idle");

endmodule : pc_core

// File: logic/pc_core_regs.svh
/*
  Offsets, field positions, reset values and sizes of the program
  counter core. Assumes it is included by bare name after the package.
*/
`ifndef PC_CORE_REGS_SVH
`define PC_CORE_REGS_SVH

// register addresses in the operand space
`define OFS_INDIRECT_ACCESS_PORT 6'h00
`define OFS_TIMER_CLOCK_COUNTER 6'h01
`define OFS_PROGRAM_COUNTER 6'h02
`define OFS_STATUS 6'h03
`define OFS_RAM_SELECT_POINTER 6'h04

// field positions
`define STATUS_PAGE_HI 6
`define STATUS_PAGE_LO 5
`define RSR_INDEX_HI 5
`define PORT_CONFIG_EDGE_BIT 7

// widths and sizes
`define PC_WIDTH 12
`define JUMP_FIELD_WIDTH 10
`define DATA_WORDS 64
`define STACK_DEPTH 8
`define STACK_PTR_WIDTH 3

// reset values
`define PC_RESET 12'h000
`define TCC_RESET 8'h00
`define STATUS_RESET 8'h00
`define RSR_RESET 8'h00

`endif

// File: logic/pc_core_pkg.sv
/*
  Types shared by the program counter core: sequencing commands,
  register access request, power mode.
  Assumes the decoder drives one command per instruction cycle.
*/
package pc_core_pkg;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_STEP = 4'h1,
    OP_JUMP = 4'h2,
    OP_CALL = 4'h3,
    OP_RET = 4'h4,
    OP_RET_LIT = 4'h5,
    OP_RET_INT = 4'h6,
    OP_ADD_PC = 4'h7,
    OP_MOV_PC = 4'h8
  } seq_op_t;

  typedef struct packed {
    seq_op_t op;
    logic [9:0] imm;
    logic [7:0] acc;
  } seq_cmd_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_GREEN = 2'b01,
    MODE_IDLE = 2'b11,
    MODE_SLEEP = 2'b10
  } power_mode_t;

endpackage : pc_core_pkg

// File: sim/prog_store_model.sv
/*
  Program store model: decoded commands kept by word address.
  Assumes the bench fills mem before raising run_in.
*/
`timescale 1ns/10ps
module prog_store_model
  import pc_core_pkg::*;
(
  // fetch side
  input wire logic run_in,
  input wire logic [11:0] addr_in,
  // command to the core
  output seq_cmd_t cmd_out
);
  seq_cmd_t mem [4096];
  // a stopped store issues no-ops so the counter holds
  assign cmd_out = run_in ? mem[addr_in] : '0;
endmodule : prog_store_model

// File: sim/program_counter_core_regs_tb.sv
/*
  Self-checking bench of pc_core: program trace table, register port,
  timer, pin events and reset pin.
  Assumes the package, the design and the store model are compiled first.
*/
`timescale 1ns/10ps
`include "pc_core_regs.svh"
module program_counter_core_regs_tb;
  import pc_core_pkg::*;
  typedef struct {logic [11:0] a; seq_cmd_t c; logic [11:0] n;} row_t;
  logic mclk, sys_rst = 1, rst_n_pin = 1, run = 0, src_ext = 0;
  logic tcc_pin = 0, pa = 0, pb = 1;
  logic [7:0] cfg = 8'h80, p6 = 8'h00, p8 = 8'h00, p8en = 8'h02;
  power_mode_t mode = MODE_NORMAL;
  reg_req_t req = '0;
  seq_cmd_t cmd;
  logic [11:0] fetch;
  logic [7:0] rdata, timer_clock_counter;
  logic [1:0] page;
  logic rvalid, irqa_o, irqb_o, wake, in_rst, ovf;
  int n_mismatch = 0, checked = 0, na = 0, nb = 0, nw = 0;
  // page 2 for rows 0..11, page 0 for row 12, page 3 for rows 13..23,
  // which end in a ninth nested call
  row_t rows [24] = '{
    '{12'h000, '{OP_STEP, 10'h000, 8'h00}, 12'h001},
    '{12'h001, '{OP_JUMP, 10'h155, 8'h00}, 12'h955},
    '{12'h955, '{OP_CALL, 10'h3FF, 8'h00}, 12'hBFF},
    '{12'hBFF, '{OP_STEP, 10'h000, 8'h00}, 12'hC00},
    '{12'hC00, '{OP_ADD_PC, 10'h000, 8'hFF}, 12'hCFF},
    '{12'hCFF, '{OP_ADD_PC, 10'h000, 8'h01}, 12'hD00},
    '{12'hD00, '{OP_MOV_PC, 10'h000, 8'h34}, 12'h934},
    '{12'h934, '{OP_RET, 10'h000, 8'h00}, 12'h956},
    '{12'h956, '{OP_CALL, 10'h010, 8'h00}, 12'h810},
    '{12'h810, '{OP_CALL, 10'h020, 8'h00}, 12'h820},
    '{12'h820, '{OP_RET_LIT, 10'h000, 8'h00}, 12'h811},
    '{12'h811, '{OP_RET_INT, 10'h000, 8'h00}, 12'h957},
    '{12'h957, '{OP_CALL, 10'h100, 8'h00}, 12'h100},
    '{12'h100, '{OP_RET, 10'h000, 8'h00}, 12'h958},
    '{12'h958, '{OP_JUMP, 10'h000, 8'h00}, 12'hC00},
    '{12'hC00, '{OP_CALL, 10'h001, 8'h00}, 12'hC01},
    '{12'hC01, '{OP_CALL, 10'h002, 8'h00}, 12'hC02},
    '{12'hC02, '{OP_CALL, 10'h003, 8'h00}, 12'hC03},
    '{12'hC03, '{OP_CALL, 10'h004, 8'h00}, 12'hC04},
    '{12'hC04, '{OP_CALL, 10'h005, 8'h00}, 12'hC05},
    '{12'hC05, '{OP_CALL, 10'h006, 8'h00}, 12'hC06},
    '{12'hC06, '{OP_CALL, 10'h007, 8'h00}, 12'hC07},
    '{12'hC07, '{OP_CALL, 10'h008, 8'h00}, 12'hC08},
    '{12'hC08, '{OP_CALL, 10'h009, 8'h00}, 12'hC09}};

  pc_core DUT (.mclk_in(mclk), .sys_rst_in(sys_rst), .reset_n_pin_in(rst_n_pin),
    .cmd_in(cmd), .req_in(req), .mode_in(mode), .tcc_src_ext_in(src_ext),
    .port_config_reg_in(cfg), .tcc_pin_in(tcc_pin), .ext_irq_a_in(pa),
    .ext_irq_b_in(pb), .port6_pin_in(p6), .port8_pin_in(p8), .port8_gpio_en_in(p8en),
    .fetch_addr_out(fetch), .rdata_out(rdata), .rdata_valid_out(rvalid),
    .page_select_bits_out(page), .timer_clock_counter_out(timer_clock_counter), .irq_a_out(irqa_o),
    .irq_b_out(irqb_o), .wake_out(wake), .stack_overflow_out(ovf), .in_reset_out(in_rst));
  prog_store_model prog (.run_in(run), .addr_in(fetch), .cmd_out(cmd));

  initial begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (irqa_o === 1'b1) na++;
    if (irqb_o === 1'b1) nb++;
    if (wake === 1'b1) nw++;
  end

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    if (n_mismatch == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{1'b0, 1'b1, a, d};
    @(posedge mclk);
    req <= '0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge mclk);
    req <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge mclk);
    req <= '0;
    #1 chk(12'(rvalid), 12'h001);
    chk({4'h0, rdata}, {4'h0, e});
  endtask : rd
  task automatic run_rows(input int first, input int last);
    for (int i = first; i <= last; i++) prog.mem[rows[i].a] = rows[i].c;
    @(posedge mclk);
    run <= 1;
    for (int i = first; i <= last; i++) begin
      @(posedge mclk);
      if (i == last) run <= 0;
      #1 chk(fetch, rows[i].n);
    end
  endtask : run_rows
  // pin edges need two edges to sync plus one to pulse
  task automatic settle;
    repeat (6) @(posedge mclk);
  endtask : settle

  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 0;
    #1 chk(12'(in_rst), 12'h001);
    chk(fetch, 12'h000);
    repeat (4) @(posedge mclk);
    #1 chk(12'(in_rst), 12'h000);
    wr(`OFS_STATUS, 8'h40);
    #1 chk(12'(page), 12'h002);
    run_rows(0, 11);
    wr(`OFS_STATUS, 8'h00);
    run_rows(12, 12);
    wr(`OFS_STATUS, 8'h60);
    run_rows(13, 13);
    chk(12'(page), 12'h003);
    run_rows(14, 22);
    chk(12'(ovf), 12'h000);
    run_rows(23, 23);
    chk(12'(ovf), 12'h001);
    wr(`OFS_PROGRAM_COUNTER, 8'h77);
    #1 chk(fetch, 12'hC77);
    rd(`OFS_PROGRAM_COUNTER, 8'h77);
    rd(`OFS_STATUS, 8'h60);
    wr(`OFS_RAM_SELECT_POINTER, 8'hD2);
    wr(`OFS_INDIRECT_ACCESS_PORT, 8'hAB);
    rd(6'h12, 8'hAB);
    wr(6'h12, 8'h5C);
    rd(`OFS_INDIRECT_ACCESS_PORT, 8'h5C);
    @(posedge mclk) mode <= MODE_IDLE;
    wr(`OFS_TIMER_CLOCK_COUNTER, 8'hF0);
    rd(`OFS_TIMER_CLOCK_COUNTER, 8'hF0);
    @(posedge mclk) src_ext <= 1;
    repeat (3) begin
      @(posedge mclk) tcc_pin <= 1;
      settle();
      @(posedge mclk) tcc_pin <= 0;
      settle();
    end
    rd(`OFS_TIMER_CLOCK_COUNTER, 8'hF3);
    @(posedge mclk) mode <= MODE_GREEN;
    src_ext <= 0;
    wr(`OFS_TIMER_CLOCK_COUNTER, 8'h10);
    repeat (4) @(posedge mclk);
    #1 chk({4'h0, timer_clock_counter}, 12'h014);
    @(posedge mclk) mode <= MODE_NORMAL;
    repeat (2) @(posedge mclk);
    #1 chk({4'h0, timer_clock_counter}, 12'h017);
    @(posedge mclk) pa <= 1;
    settle();
    chk(12'(na), 12'h001);
    @(posedge mclk) pa <= 0;
    settle();
    chk(12'(na), 12'h001);
    @(posedge mclk) cfg <= 8'h00;
    @(posedge mclk) pa <= 1;
    settle();
    chk(12'(na), 12'h001);
    @(posedge mclk) pa <= 0;
    settle();
    chk(12'(na), 12'h002);
    @(posedge mclk) pb <= 0;
    settle();
    chk(12'(nb), 12'h001);
    @(posedge mclk) pb <= 1;
    settle();
    chk(12'(nb), 12'h001);
    chk(12'(nw), 12'h000);
    @(posedge mclk) mode <= MODE_SLEEP;
    @(posedge mclk) p6 <= 8'h80;
    settle();
    chk(12'(nw), 12'h001);
    @(posedge mclk) p8 <= 8'h01;
    settle();
    chk(12'(nw), 12'h001);
    @(posedge mclk) p8 <= 8'h03;
    settle();
    chk(12'(nw), 12'h002);
    @(posedge mclk) mode <= MODE_IDLE;
    @(posedge mclk) pa <= 1;
    settle();
    chk(12'(nw), 12'h003);
    @(posedge mclk) pb <= 0;
    settle();
    chk(12'(nw), 12'h004);
    @(posedge mclk) mode <= MODE_NORMAL;
    @(posedge mclk) rst_n_pin <= 0;
    repeat (10) @(posedge mclk);
    #1 chk(12'(in_rst), 12'h001);
    chk(fetch, 12'h000);
    @(posedge mclk) rst_n_pin <= 1;
    repeat (4) @(posedge mclk);
    #1 chk(12'(in_rst), 12'h000);
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    end_of_test();
  end
endmodule : program_counter_core_regs_tb
